// file: bench/pmc_assertions.sv
// port assertions for the power mode controller
`timescale 1ns/10ps
`default_nettype none
module pmc_chk import pmc_pkg::*; (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic mode_wr_i,
    input wire logic [1:0] mode_sel_i,
    input wire logic wake_i,
    input wire logic cpu_clk_o,
    input wire logic periph_clk_o,
    input wire logic clk_out_o,
    input wire logic osc_en_o,
    input wire pmc_mode_e mode_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    // gates settle within a few edges of the mode output, hence the repeats
    chk_mode_legal: assert property (mode_o != 2'h3) else $error("mode");
    chk_osc_off: assert property (osc_en_o == (mode_o != PMC_PDOWN)) else $error("osc");
    chk_idle_cpu: assert property ((mode_o != PMC_ACTIVE)[*3] |-> !cpu_clk_o)
        else $error("cpu");
    chk_pdown_clk: assert property ((mode_o == PMC_PDOWN)[*3] |-> !periph_clk_o)
        else $error("pd");
    chk_idle_per: assert property ((mode_o == PMC_IDLE)[*5] |-> $changed(periph_clk_o))
        else $error("per");
    chk_out_same: assert property (clk_out_o == periph_clk_o) else $error("out");
    chk_write_mode: assert property (mode_wr_i && !wake_i && mode_sel_i != 3
        |-> ##2 mode_o == $past(mode_sel_i, 2)) else $error("wr");
    chk_hold_mode: assert property (!wake_i && (!mode_wr_i || &mode_sel_i)
        |-> ##2 $stable(mode_o)) else $error("hold");
    cover property (mode_o == PMC_IDLE);
    cover property (mode_o == PMC_PDOWN);
    cover property (wake_i && mode_o == PMC_PDOWN);
endmodule
bind pmc_power_ctrl pmc_chk i_chk (.clock_i, .rst_n_i, .mode_wr_i, .mode_sel_i, .wake_i,
    .cpu_clk_o, .periph_clk_o, .clk_out_o, .osc_en_o, .mode_o);
`default_nettype wire

// file: bench/power_mode_clock_gating_tb_top.sv
// random mode walk against a mode model
`timescale 1ns/10ps
`default_nettype none
module power_mode_clock_gating_tb_top;
    import pmc_pkg::*;
    logic clock_i = 1'b0, rst_n_i = 1'b0, mode_wr_i = 1'b0, wake_i = 1'b0;
    logic [1:0] mode_sel_i = 2'h0, m, c;
    logic cpu_clk_o, periph_clk_o, clk_out_o, osc_en_o;
    pmc_mode_e mode_o;
    int mismatches = 0, n_checks = 0, i;
    logic [31:0] r = 32'h72089564;
    always #50 clock_i = ~clock_i;
    pmc_power_ctrl i_dut (.clock_i, .rst_n_i, .mode_wr_i, .mode_sel_i, .wake_i,
        .cpu_clk_o, .periph_clk_o, .clk_out_o, .osc_en_o, .mode_o);
    function automatic logic [31:0] nxt(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic cmp(input logic [2:0] got, input logic [2:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch %0t %h %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test;
        if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // one request, then six falling edges to wait out the gate latency
    initial begin
        m = 2'h0;
        repeat (16) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (i = 0; i < 40; i++) begin
            r = nxt(r);
            @(posedge clock_i);
            mode_wr_i <= ~&r[5:4];
            mode_sel_i <= r[1:0];
            wake_i <= &r[3:2];
            if (&r[3:2] && m != 0) m = 2'h0;
            else if (!(&r[5:4]) && r[1:0] != 3) m = r[1:0];
            @(posedge clock_i);
            mode_wr_i <= 1'b0;
            wake_i <= 1'b0;
            repeat (6) @(negedge clock_i);
            c = {cpu_clk_o, periph_clk_o};
            @(negedge clock_i);
            cmp({mode_o, osc_en_o}, {m, m != 2});
            cmp({c ^ {cpu_clk_o, periph_clk_o}, clk_out_o ^ periph_clk_o}, {m == 0, m != 2, 1'b0});
        end
        end_of_test;
    end
endmodule
`default_nettype wire

// file: logic/pmc_gate_cell.sv
// clock gate cell: enable captured while the divided clock is low
`timescale 1ns/10ps
`default_nettype none
module pmc_gate_cell (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic phase_i,
    input wire logic enable_i,
    output logic gclk_o
);
    logic en_r;

    // enable only moves while the phase is low so a gated pulse is never clipped
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_r <= 1'b0;
        end else if (!phase_i) begin
            en_r <= enable_i;
        end
    end

    // register the gated phase so the output is glitch free and held at zero
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gclk_o <= 1'b0;
        end else begin
            gclk_o <= (~phase_i) & en_r; // high only for the half after a low phase
        end
    end
endmodule
`default_nettype wire

// file: logic/pmc_map.svh
// constants for the power mode clock gating block
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH
`define PMC_MODE_ACTIVE 2'h0
`define PMC_MODE_IDLE 2'h1
`define PMC_MODE_PDOWN 2'h2
`define PMC_DIV_RESET 1'h0
`define PMC_OSC_RESET 1'h1
`endif

// file: logic/pmc_pkg.sv
// types for the power mode clock gating block
package pmc_pkg;
    typedef enum logic [1:0] {
        PMC_ACTIVE,
        PMC_IDLE,
        PMC_PDOWN
    } pmc_mode_e;

    typedef struct packed {
        logic cpu_en;
        logic periph_en;
        logic osc_en;
    } pmc_gate_s;
endpackage

// file: logic/pmc_power_ctrl.sv
// power mode controller with divide-by-two clock and gated clock outputs
`timescale 1ns/10ps
`default_nettype none
`include "pmc_map.svh"
module pmc_power_ctrl (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic mode_wr_i,
    input wire logic [1:0] mode_sel_i,
    input wire logic wake_i,
    output logic cpu_clk_o,
    output logic periph_clk_o,
    output logic clk_out_o,
    output logic osc_en_o,
    output pmc_pkg::pmc_mode_e mode_o
);
    import pmc_pkg::*;

    logic phase_r;
    pmc_mode_e mode_r;
    pmc_mode_e mode_nxt;
    pmc_gate_s gate;
    logic [2:0] gate_en;
    logic [2:0] gclk;

    // divide-by-two source of every phase clock
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_r <= `PMC_DIV_RESET;
        end else begin
            phase_r <= ~phase_r;
        end
    end

    // mode request decode; wake leaves idle or powerdown for active
    always_comb begin
        mode_nxt = mode_r;
        if (wake_i && mode_r != PMC_ACTIVE) begin
            mode_nxt = PMC_ACTIVE;
        end else if (mode_wr_i) begin
            case (mode_sel_i)
                `PMC_MODE_ACTIVE: mode_nxt = PMC_ACTIVE;
                `PMC_MODE_IDLE: mode_nxt = PMC_IDLE;
                `PMC_MODE_PDOWN: mode_nxt = PMC_PDOWN;
                default: mode_nxt = mode_r; // unused code ignored
            endcase
        end
    end

    // one mode register, so exactly one mode holds; no state is cleared on entry
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mode_r <= PMC_ACTIVE;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // gate enables per mode
    always_comb begin
        gate = '{cpu_en: 1'b1, periph_en: 1'b1, osc_en: 1'b1};
        case (mode_r)
            PMC_ACTIVE: gate = '{cpu_en: 1'b1, periph_en: 1'b1, osc_en: 1'b1};
            PMC_IDLE: gate = '{cpu_en: 1'b0, periph_en: 1'b1, osc_en: 1'b1};
            PMC_PDOWN: gate = '{cpu_en: 1'b0, periph_en: 1'b0, osc_en: 1'b0};
            default: gate = '{cpu_en: 1'b1, periph_en: 1'b1, osc_en: 1'b1};
        endcase
    end

    // oscillator enable and mode flag registered
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_en_o <= `PMC_OSC_RESET;
            mode_o <= PMC_ACTIVE;
        end else begin
            osc_en_o <= gate.osc_en;
            mode_o <= mode_r;
        end
    end

    // cpu, peripheral and clock-out enables; clock-out shares the peripheral gate
    assign gate_en = {gate.periph_en, gate.periph_en, gate.cpu_en};

    // one gate cell per clock; enables latched only in the low phase
    for (genvar g = 0; g < 3; g++) begin : g_gate
        pmc_gate_cell u_gate (
            .clock_i(clock_i),
            .rst_n_i(rst_n_i),
            .phase_i(phase_r),
            .enable_i(gate_en[g]),
            .gclk_o(gclk[g])
        );
    end

    // outputs taken straight from the gate cell flip-flops
    assign cpu_clk_o = gclk[0];
    assign periph_clk_o = gclk[1];
    assign clk_out_o = gclk[2];
endmodule
`default_nettype wire
